// ==== verilog/lsa_datapath.sv ====
// Execution datapath for loads, stores, address and integer arithmetic
// Notes on behaviour
// - PC word load address is aligned PC plus sext 19-bit imm times four.
// - PC unsigned word load adds aligned PC and sext 19-bit imm times eight.
// - PC dword load clears PC low three bits, adds sext 18-bit imm times 8.
// - A consumer of the just-loaded register stalls until the cycle its load data returns.
// - Byte and half loads are sign or zero extended per opcode; words pass unchanged.
// - The address names the item's low-order byte, MSB in big endian.
// - Byte lanes come from size and low address bits, mirrored by endianness.
// - A misaligned size and address pair raises an address error.
// - Immediates are sign extended for arithmetic, zero extended for logic.
// - Scaled add shifts one register left by one to four, then adds.
// - Add upper immediate adds sext imm shifted by sixteen to register.
// - PC add puts own address plus sext 19-bit imm times four in rs.
// - PC upper add adds own address and sext 16-bit imm shifted sixteen.
// - Aligned PC upper add clears the low sixteen bits of that sum.
// - Unsigned-named immediate adds sign extend and never flag overflow.
// - Bit reversal flips bit order in each byte, bytes stay put.
// - Extract returns a word slice of both operands at byte steps.
// - Low multiplies give low product half, high ones the upper half.
// - Divide writes the quotient only, modulus the remainder only.
// - Multiplies go to the multiplier while later instructions advance.
// - The multiplier keeps a low product for a following high on the same operands that starts once the low result is out.
// - The primary opcode is the top six bits of each instruction word.
`timescale 1ns/1ps
module lsa_datapath
   import lsa_pkg::*;
#(
   parameter int unsigned WIDTH = XLEN
)
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_valid,
   input wire lsa_pkg::lsa_op_e i_op,
   input wire logic [31:0] i_instr,
   input wire logic [31:0] i_pc,
   input wire logic [31:0] i_rs_val,
   input wire logic [31:0] i_rt_val,
   input wire logic [4:0] i_rs_idx,
   input wire logic [4:0] i_rt_idx,
   input wire logic [4:0] i_dest_idx,
   input wire lsa_pkg::lsa_size_e i_size,
   input wire logic i_load_signed,
   input wire logic [2:0] i_scale,
   input wire logic [1:0] i_extract_sel,
   input wire logic i_big_endian,
   input wire logic [63:0] i_mem_rdata,
   input wire logic i_mem_rvalid,
   output logic o_stall,
   output logic [5:0] o_opcode,
   output logic o_result_valid,
   output logic [31:0] o_result,
   output logic [63:0] o_dword_result,
   output logic [4:0] o_result_idx,
   output logic o_mem_req,
   output logic o_mem_write,
   output logic o_mem_dword,
   output logic [31:0] o_mem_addr,
   output logic [3:0] o_mem_lanes,
   output logic [31:0] o_mem_wdata,
   output logic o_addr_error,
   output logic o_overflow
);
   import lsa_pkg::*;

   // Upper bound of the multiplier answer time, for the assertion below
   localparam int MUL_WAIT = MUL_LATENCY;

   logic [31:0] res_next;
   logic [1:0] wsh_next;
   logic [7:0] ld_byte;
   logic [15:0] ld_half;
   logic [31:0] addr_next;
   logic res_now;
   logic mem_now;
   logic ovf_next;
   logic [3:0] lanes_next;
   logic mis_next;
   logic [32:0] wide_sum;
   logic load_pend_reg;
   logic [4:0] load_idx_reg;
   lsa_size_e load_size_reg;
   logic load_sgn_reg;
   logic [1:0] load_off_reg;
   logic load_be_reg;
   logic load_dw_reg;
   logic hazard;
   logic take;
   logic mul_start;
   logic mul_done;
   logic [31:0] mul_res;
   logic [4:0] mul_idx_reg;
   logic [31:0] quot;
   logic [31:0] rem;

   // Sign-extended immediate of a given width, scaled by a shift
   function automatic logic [31:0] sext_sh(input logic [31:0] v,
                                           input int unsigned w,
                                           input int unsigned sh);
      logic [31:0] m;
      m = v << (32 - w);
      return 32'($signed(m) >>> (32 - w)) << sh;
   endfunction

   function automatic logic [31:0] rev_bytes(input logic [31:0] v);
      logic [31:0] r;
      r = ZERO32;
      for (int i = 0; i < 32; i++) begin
         r[i] = v[(i / 8) * 8 + 7 - (i % 8)];
      end
      return r;
   endfunction

   // lane of the item's low byte; big endian mirrors byte number
   function automatic logic [1:0] lane_of(input logic [1:0] off,
                                          input logic be);
      return be ? 2'(LOW_MASK2 - off) : off;
   endfunction

   // primary opcode field, registered like every other output
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_opcode <= 6'h00;
      end else begin
         o_opcode <= i_instr[OPC_MSB:OPC_LSB];
      end
   end

   // consumer of the pending load register must wait
   assign hazard = load_pend_reg && !i_mem_rvalid &&
                   (i_rs_idx == load_idx_reg || i_rt_idx == load_idx_reg);
   assign take = i_valid && !hazard;

   // item picked from the returned data by its lane
   assign ld_byte = i_mem_rdata[8 * int'(lane_of(load_off_reg,
                    load_be_reg)) +: 8];
   assign ld_half = i_mem_rdata[16 * int'(load_off_reg[1] ^ load_be_reg)
                    +: 16];

   // Signed and unsigned division results, zero divisor gives zero
   always_comb begin
      quot = ZERO32;
      rem = ZERO32;
      if (i_rt_val != ZERO32) begin
         if (i_op == LSA_OP_DIV_S || i_op == LSA_OP_MOD_S) begin
            quot = 32'($signed(i_rs_val) / $signed(i_rt_val));
            rem = 32'($signed(i_rs_val) % $signed(i_rt_val));
         end else begin
            quot = i_rs_val / i_rt_val;
            rem = i_rs_val % i_rt_val;
         end
      end
   end

   // Operation decode and result formation
   always_comb begin
      res_next = ZERO32;
      addr_next = ZERO32;
      res_now = 1'b0;
      mem_now = 1'b0;
      ovf_next = 1'b0;
      lanes_next = LANES_NONE;
      mis_next = 1'b0;
      wsh_next = 2'h0;
      wide_sum = 33'($signed(i_rs_val)) +
                 33'($signed(sext_sh(32'(i_instr[15:0]), IMM16_W, 0)));
      case (i_op)
         LSA_OP_LOAD, LSA_OP_STORE: begin
            addr_next = i_rs_val + sext_sh(32'(i_instr[15:0]), IMM16_W, 0);
            mem_now = 1'b1;
            case (i_size)
               LSA_SIZE_BYTE: begin
                  wsh_next = lane_of(addr_next[1:0], i_big_endian);
                  lanes_next = LANE_B << wsh_next;
               end
               LSA_SIZE_HALF: begin
                  mis_next = addr_next[0];
                  wsh_next = i_big_endian ? 2'(2'h2 - addr_next[1:0]) :
                     addr_next[1:0];
                  lanes_next = LANE_H << wsh_next;
               end
               default: begin
                  mis_next = addr_next[1:0] != 2'h0;
                  lanes_next = LANE_W;
               end
            endcase
            if (mis_next) begin
               lanes_next = LANES_NONE;
            end
         end
         LSA_OP_PC_WORD: begin
            // word aligned PC plus scaled offset
            addr_next = (i_pc & ~32'(LOW_MASK2)) +
               sext_sh(32'(i_instr[18:0]), IMM19_W, WORD_SHIFT);
            mem_now = 1'b1;
            lanes_next = LANE_W;
         end
         LSA_OP_PC_UWORD: begin
            addr_next = (i_pc & ~32'(LOW_MASK2)) +
               sext_sh(32'(i_instr[18:0]), IMM19_W, DWORD_SHIFT);
            mem_now = 1'b1;
            lanes_next = LANE_W;
         end
         LSA_OP_PC_DWORD: begin
            addr_next = (i_pc & ~32'(LOW_MASK3)) +
               sext_sh(32'(i_instr[17:0]), IMM18_W, DWORD_SHIFT);
            mem_now = 1'b1;
            lanes_next = LANE_W;
         end
         LSA_OP_ADD_IMM, LSA_OP_ADD_IMM_U: begin
            // arithmetic immediate is signed; no overflow if U
            res_next = wide_sum[31:0];
            res_now = 1'b1;
            ovf_next = (i_op == LSA_OP_ADD_IMM) &&
                       (wide_sum[32] != wide_sum[31]);
         end
         LSA_OP_LOGIC_IMM: begin
            res_next = i_rs_val | 32'(i_instr[15:0]);
            res_now = 1'b1;
         end
         LSA_OP_SCALED_ADD: begin
            // scale clamped to one through four
            res_next = (i_rs_val << ((i_scale < 3'(SCALE_MIN)) ?
               3'(SCALE_MIN) : (i_scale > 3'(SCALE_MAX)) ?
               3'(SCALE_MAX) : i_scale)) + i_rt_val;
            res_now = 1'b1;
         end
         LSA_OP_ADD_UPPER: begin
            res_next = i_rs_val + (32'(i_instr[15:0]) << UPPER_SHIFT);
            res_now = 1'b1;
         end
         LSA_OP_PC_ADD: begin
            // own address plus scaled 19-bit offset
            res_next = i_pc +
               sext_sh(32'(i_instr[18:0]), IMM19_W, WORD_SHIFT);
            res_now = 1'b1;
         end
         LSA_OP_PC_UPPER: begin
            res_next = i_pc + (32'(i_instr[15:0]) << UPPER_SHIFT);
            res_now = 1'b1;
         end
         LSA_OP_PC_ALIGNED: begin
            // low sixteen bits forced to zero
            res_next = i_pc + (32'(i_instr[15:0]) << UPPER_SHIFT);
            res_next[15:0] = LOW16_ZERO;
            res_now = 1'b1;
         end
         LSA_OP_BIT_REV: begin
            res_next = rev_bytes(i_rt_val);
            res_now = 1'b1;
         end
         LSA_OP_EXTRACT: begin
            res_next = 32'({i_rs_val, i_rt_val} >> (32 - 8 *
                       int'(i_extract_sel)));
            if (i_extract_sel == 2'h0) begin
               res_next = i_rt_val;
            end
            res_now = 1'b1;
         end
         LSA_OP_DIV_S, LSA_OP_DIV_U: begin
            res_next = quot;
            res_now = 1'b1;
         end
         LSA_OP_MOD_S, LSA_OP_MOD_U: begin
            res_next = rem;
            res_now = 1'b1;
         end
         default: begin
            res_next = ZERO32;
         end
      endcase
   end

   // multiplies leave for the multiplier without holding the pipe
   assign mul_start = take && (i_op == LSA_OP_MUL_LO_S ||
      i_op == LSA_OP_MUL_LO_U || i_op == LSA_OP_MUL_HI_S ||
      i_op == LSA_OP_MUL_HI_U);

   lsa_mul_unit u_mul (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_start(mul_start),
      .i_high(i_op == LSA_OP_MUL_HI_S || i_op == LSA_OP_MUL_HI_U),
      .i_signed(i_op == LSA_OP_MUL_LO_S || i_op == LSA_OP_MUL_HI_S),
      .i_a(i_rs_val),
      .i_b(i_rt_val),
      .o_done(mul_done),
      .o_result(mul_res),
      .o_reused()
   );

   // Destination of the in-flight multiply
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         mul_idx_reg <= 5'h00;
      end else if (mul_start) begin
         mul_idx_reg <= i_dest_idx;
      end
   end

   // Pending load tracking for the interlock and return formatting
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         load_pend_reg <= 1'b0;
         load_idx_reg <= 5'h00;
         load_size_reg <= LSA_SIZE_WORD;
         load_sgn_reg <= 1'b0;
         load_off_reg <= 2'h0;
         load_be_reg <= 1'b0;
         load_dw_reg <= 1'b0;
      end else if (take && mem_now && i_op != LSA_OP_STORE && !mis_next) begin
         load_pend_reg <= 1'b1;
         load_idx_reg <= i_dest_idx;
         load_size_reg <= (i_op == LSA_OP_LOAD) ? i_size : LSA_SIZE_WORD;
         load_sgn_reg <= (i_op == LSA_OP_LOAD) ? i_load_signed :
                         (i_op == LSA_OP_PC_WORD);
         load_off_reg <= addr_next[1:0];
         load_be_reg <= i_big_endian;
         load_dw_reg <= (i_op == LSA_OP_PC_DWORD);
      end else if (i_mem_rvalid) begin
         load_pend_reg <= 1'b0;
      end
   end

   // Memory request outputs
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_mem_req <= 1'b0;
         o_mem_write <= 1'b0;
         o_mem_dword <= 1'b0;
         o_mem_addr <= ZERO32;
         o_mem_lanes <= LANES_NONE;
         o_mem_wdata <= ZERO32;
         o_addr_error <= 1'b0;
      end else begin
         // misaligned access raises error, no request
         o_mem_req <= take && mem_now && !mis_next;
         o_addr_error <= take && mem_now && mis_next;
         o_mem_write <= i_op == LSA_OP_STORE;
         o_mem_dword <= i_op == LSA_OP_PC_DWORD;
         o_mem_addr <= addr_next;
         o_mem_lanes <= lanes_next;
         // Store data moves to the lowest lane of the item
         o_mem_wdata <= i_rt_val << (8 * int'(wsh_next));
      end
   end

   // Result writeback: loads, multiplier, then direct results
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_result_valid <= 1'b0;
         o_result <= ZERO32;
         o_dword_result <= 64'h0000_0000_0000_0000;
         o_result_idx <= 5'h00;
         o_overflow <= 1'b0;
         o_stall <= 1'b0;
      end else begin
         o_stall <= i_valid && hazard;
         o_overflow <= take && ovf_next;
         o_result_valid <= 1'b0;
         if (i_mem_rvalid && load_pend_reg) begin
            o_result_valid <= 1'b1;
            o_result_idx <= load_idx_reg;
            o_dword_result <= i_mem_rdata;
            case (load_size_reg)
               LSA_SIZE_BYTE: begin
                  // Each arm widened alone so the sign survives
                  o_result <= load_sgn_reg ? 32'($signed(ld_byte)) :
                     32'(ld_byte);
               end
               LSA_SIZE_HALF: begin
                  o_result <= load_sgn_reg ? 32'($signed(ld_half)) :
                     32'(ld_half);
               end
               default: begin
                  o_result <= i_mem_rdata[31:0];
               end
            endcase
         end else if (mul_done) begin
            o_result_valid <= 1'b1;
            o_result_idx <= mul_idx_reg;
            o_result <= mul_res;
         end else if (take && res_now && !ovf_next) begin
            o_result_valid <= 1'b1;
            o_result_idx <= (i_op == LSA_OP_PC_ADD) ? i_rs_idx : i_dest_idx;
            o_result <= res_next;
         end
      end
   end

   // Assertions
   property p_stall_hazard;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_valid && hazard) |=> o_stall && !o_mem_req && !o_addr_error;
   endproperty
   a_stall_hazard: assert property (p_stall_hazard)
      else $error("stall missing on load use");

   property p_mis_no_req;
      @(posedge i_clock) disable iff (!i_nrst)
      o_addr_error |-> !o_mem_req;
   endproperty
   a_mis_no_req: assert property (p_mis_no_req)
      else $error("request issued with address error");

   property p_aligned_low;
      @(posedge i_clock) disable iff (!i_nrst)
      (take && i_op == LSA_OP_PC_ALIGNED) |=>
         o_result[15:0] == LOW16_ZERO;
   endproperty
   a_aligned_low: assert property (p_aligned_low)
      else $error("aligned upper add low bits not zero");

   property p_no_ovf_u;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_valid && i_op == LSA_OP_ADD_IMM_U) |=> !o_overflow;
   endproperty
   a_no_ovf_u: assert property (p_no_ovf_u)
      else $error("overflow from unsigned add");

   property p_dword_align;
      @(posedge i_clock) disable iff (!i_nrst)
      (o_mem_req && o_mem_dword) |-> o_mem_addr[2:0] == 3'h0;
   endproperty
   a_dword_align: assert property (p_dword_align)
      else $error("dword address not aligned");

   property p_mul_done;
      @(posedge i_clock) disable iff (!i_nrst)
      mul_start |-> ##[1:MUL_WAIT] mul_done;
   endproperty
   a_mul_done: assert property (p_mul_done)
      else $error("multiplier result late");

   property p_opcode;
      @(posedge i_clock) disable iff (!i_nrst)
      1'b1 |=> o_opcode == $past(i_instr[OPC_MSB:OPC_LSB]);
   endproperty
   a_opcode: assert property (p_opcode)
      else $error("opcode field wrong");

   property p_word_lanes;
      @(posedge i_clock) disable iff (!i_nrst)
      (o_mem_req && !o_mem_dword && o_mem_addr[1:0] != 2'h0) |->
         o_mem_lanes != LANE_W;
   endproperty
   a_word_lanes: assert property (p_word_lanes)
      else $error("full word lanes on unaligned address");
endmodule

// ==== verilog/lsa_pkg.sv ====
// Package of constants and types for the load/store and ALU datapath
package lsa_pkg;
   localparam int unsigned XLEN = 32;
   localparam int unsigned OPC_MSB = 31;
   localparam int unsigned OPC_LSB = 26;
   localparam int unsigned IMM19_W = 19;
   localparam int unsigned IMM18_W = 18;
   localparam int unsigned IMM16_W = 16;
   localparam int unsigned WORD_SHIFT = 2;
   localparam int unsigned DWORD_SHIFT = 3;
   localparam int unsigned UPPER_SHIFT = 16;
   localparam int unsigned DWORD_W = 64;
   localparam int unsigned SCALE_MIN = 1;
   localparam int unsigned SCALE_MAX = 4;
   localparam int unsigned MUL_LATENCY = 2;
   localparam logic [1:0] LOW_MASK2 = 2'h3;
   localparam logic [2:0] LOW_MASK3 = 3'h7;
   localparam logic [15:0] LOW16_ZERO = 16'h0000;
   localparam logic [3:0] LANES_NONE = 4'h0;
   localparam logic [3:0] LANE_B = 4'h1;
   localparam logic [3:0] LANE_H = 4'h3;
   localparam logic [3:0] LANE_W = 4'hF;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   // Operation selector offered by the pipeline
   typedef enum logic [4:0] {
      LSA_OP_NONE,
      LSA_OP_LOAD,
      LSA_OP_STORE,
      LSA_OP_PC_WORD,
      LSA_OP_PC_UWORD,
      LSA_OP_PC_DWORD,
      LSA_OP_ADD_IMM,
      LSA_OP_ADD_IMM_U,
      LSA_OP_LOGIC_IMM,
      LSA_OP_SCALED_ADD,
      LSA_OP_ADD_UPPER,
      LSA_OP_PC_ADD,
      LSA_OP_PC_UPPER,
      LSA_OP_PC_ALIGNED,
      LSA_OP_BIT_REV,
      LSA_OP_EXTRACT,
      LSA_OP_MUL_LO_S,
      LSA_OP_MUL_LO_U,
      LSA_OP_MUL_HI_S,
      LSA_OP_MUL_HI_U,
      LSA_OP_DIV_S,
      LSA_OP_DIV_U,
      LSA_OP_MOD_S,
      LSA_OP_MOD_U
   } lsa_op_e;

   // Access sizes
   typedef enum logic [1:0] {
      LSA_SIZE_BYTE,
      LSA_SIZE_HALF,
      LSA_SIZE_WORD
   } lsa_size_e;
endpackage

// ==== verilog/lsa_mul_unit.sv ====
// Separate multiplier unit with low-product reuse
`timescale 1ns/1ps
module lsa_mul_unit
   import lsa_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire logic i_high,
   input wire logic i_signed,
   input wire logic [31:0] i_a,
   input wire logic [31:0] i_b,
   output logic o_done,
   output logic [31:0] o_result,
   output logic o_reused
);
   logic [63:0] prod_reg;
   logic [31:0] a_reg;
   logic [31:0] b_reg;
   logic sgn_reg;
   logic high_reg;
   logic hold_valid_reg;
   logic busy_reg;
   logic [63:0] prod_next;
   logic hit;

   // Full product of the two operands
   always_comb begin
      if (i_signed) begin
         prod_next = 64'($signed(i_a) * $signed(i_b));
      end else begin
         prod_next = 64'(i_a * i_b);
      end
   end

   // low product reuse: same operands, high part follows low part
   assign hit = i_start && i_high && hold_valid_reg && a_reg == i_a &&
                b_reg == i_b && sgn_reg == i_signed;

   // Operand capture and product hold
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         prod_reg <= 64'h0000_0000_0000_0000;
         a_reg <= ZERO32;
         b_reg <= ZERO32;
         sgn_reg <= 1'b0;
         high_reg <= 1'b0;
         hold_valid_reg <= 1'b0;
         busy_reg <= 1'b0;
         o_done <= 1'b0;
         o_result <= ZERO32;
         o_reused <= 1'b0;
      end else begin
         o_done <= 1'b0;
         o_reused <= 1'b0;
         busy_reg <= 1'b0;
         if (busy_reg) begin
            o_done <= 1'b1;
            o_result <= high_reg ? prod_reg[63:32] : prod_reg[31:0];
            hold_valid_reg <= !high_reg;
         end
         if (hit) begin
            o_done <= 1'b1;
            o_reused <= 1'b1;
            o_result <= prod_reg[63:32];
            hold_valid_reg <= 1'b0;
         end else if (i_start) begin
            prod_reg <= prod_next;
            a_reg <= i_a;
            b_reg <= i_b;
            sgn_reg <= i_signed;
            high_reg <= i_high;
            busy_reg <= 1'b1;
            hold_valid_reg <= 1'b0;
         end
      end
   end
endmodule

// ==== testbench/lsa_mem_model.sv ====
// Data memory model that answers loads after a fixed delay
`timescale 1ns/1ps
module lsa_mem_model #(
   parameter int DELAY = 3,
   parameter logic [31:0] WORD = 32'h0000_0000
)
(
   input wire logic i_clock,
   input wire logic i_req,
   input wire logic i_write,
   output logic o_rvalid = 1'b0,
   output logic [63:0] o_rdata = 64'h0000_0000_0000_0000
);
   int cnt = 0;
   // Count down a pending read, idle bus shows inverted data
   always @(posedge i_clock) begin
      o_rvalid <= (cnt == 1);
      o_rdata <= (cnt == 1) ? {WORD, WORD} : ~{WORD, WORD};
      if (i_req && !i_write) begin
         cnt <= DELAY;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// ==== testbench/loadstore_alu_datapath_tb.sv ====
// Self-checking bench for the load/store and ALU datapath
`timescale 1ns/1ps
module loadstore_alu_datapath_tb;
   import lsa_pkg::*;
   localparam logic [31:0] W = 32'h8a7f_01fe;
   localparam logic [31:0] A = 32'h0000_1000;
   localparam logic [31:0] Z = 32'h0000_0000;
   localparam logic [31:0] N = 32'hffff_fffe;
   localparam logic [31:0] P = 32'h0000_2003;
   logic clk = 1'b0, nrst = 1'b0, valid = 1'b0, lsg = 1'b0, be = 1'b0;
   logic stl, rv, mreq, mwr, mdw, aerr, ovf, rvld;
   lsa_op_e op = LSA_OP_NONE;
   lsa_size_e size = LSA_SIZE_BYTE;
   logic [31:0] instr = Z, pc = Z, rs = Z, rt = Z, res, maddr, wd;
   logic [63:0] rdata, dres;
   logic [5:0] opc;
   logic [4:0] ridx;
   logic [3:0] lanes;
   logic [2:0] scale = 3'h0;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   // Design under test; rt index equals the load destination
   lsa_datapath lsa_datapath_i (.i_clock(clk), .i_nrst(nrst),
      .i_valid(valid), .i_op(op), .i_instr(instr), .i_pc(pc),
      .i_rs_val(rs), .i_rt_val(rt), .i_rs_idx(5'h09), .i_rt_idx(5'h05),
      .i_dest_idx(5'h05), .i_size(size), .i_load_signed(lsg),
      .i_scale(scale), .i_extract_sel(scale[1:0]), .i_big_endian(be),
      .i_mem_rdata(rdata), .i_mem_rvalid(rvld), .o_stall(stl),
      .o_opcode(opc), .o_result_valid(rv), .o_result(res),
      .o_dword_result(dres), .o_result_idx(ridx), .o_mem_req(mreq),
      .o_mem_write(mwr), .o_mem_dword(mdw), .o_mem_addr(maddr),
      .o_mem_lanes(lanes), .o_mem_wdata(wd), .o_addr_error(aerr),
      .o_overflow(ovf));
   lsa_mem_model #(.WORD(W)) lsa_mem_model_i (.i_clock(clk),
      .i_req(mreq), .i_write(mwr), .o_rvalid(rvld), .o_rdata(rdata));
   // Clock generator
   initial begin
      forever #10 clk = ~clk;
   end
   // Cycle ceiling against a hang
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Offer one instruction for a single cycle
   task automatic issue(input lsa_op_e o, input logic [31:0] ins, a, b, p);
      @(posedge clk);
      op <= o;
      instr <= ins;
      rs <= a;
      rt <= b;
      pc <= p;
      scale <= ins[2:0];
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      @(negedge clk);
   endtask
   // Wait a bounded time for the write-back pulse
   task automatic wres(input logic [31:0] ex, input logic dw);
      for (int n = 0; n < 12 && rv !== 1'b1; n++) begin
         @(negedge clk);
      end
      chk(rv, 1'b1);
      chk(dw ? dres : res, dw ? {W, W} : ex);
   endtask
   task automatic alu(input lsa_op_e o, input logic [31:0] ins, a, b, ex);
      issue(o, ins, a, b, A);
      chk(opc, ins[31:26]);
      wres(ex, 1'b0);
   endtask
   // Load, then a dependent instruction while the load is pending
   task automatic ld(input lsa_op_e o, input lsa_size_e s, input logic sg,
         b, input logic [31:0] ins, a, p, ea, ex, input logic [3:0] ln);
      @(posedge clk);
      size <= s;
      lsg <= sg;
      be <= b;
      issue(o, ins, a, Z, p);
      chk(mreq, 1'b1);
      chk(maddr, ea);
      chk(mdw, o == LSA_OP_PC_DWORD);
      chk(lanes, ln);
      issue(LSA_OP_ADD_IMM, Z, Z, Z, Z);
      chk(stl, 1'b1);
      wres(ex, o == LSA_OP_PC_DWORD);
   endtask
   task automatic bad(input lsa_size_e s, input logic [31:0] a);
      @(posedge clk);
      size <= s;
      issue(LSA_OP_LOAD, Z, a, Z, Z);
      chk(aerr, 1'b1);
      chk(mreq, 1'b0);
   endtask
   // Store of one item; write data must sit in the item's lanes
   task automatic st(input lsa_size_e s, input logic b,
         input logic [31:0] a, ex);
      @(posedge clk);
      size <= s;
      be <= b;
      issue(LSA_OP_STORE, Z, a, 32'h0000_00a5, Z);
      chk(mreq, 1'b1);
      chk(mwr, 1'b1);
      chk(wd, ex);
   endtask
   task automatic t_alu;
      alu(LSA_OP_ADD_IMM, 16'hfffe, 8'h10, Z, 8'h0e);
      alu(LSA_OP_SCALED_ADD, 4'h4, 4'h3, 4'h3, 8'h33);
      alu(LSA_OP_ADD_UPPER, 32'hfc00_8000, 16'h1234, Z,
         32'h8000_1234);
      alu(LSA_OP_PC_ADD, 20'h7_fffe, Z, Z, 12'hff8);
      chk(ridx, 5'h09);
      alu(LSA_OP_PC_UPPER, 4'h1, Z, Z, 20'h1_1000);
      alu(LSA_OP_PC_ALIGNED, 4'h2, Z, Z, 20'h2_0000);
      alu(LSA_OP_BIT_REV, Z, 32'h0123_4567, 32'h0123_4567,
         32'h80c4_a2e6);
      alu(LSA_OP_EXTRACT, Z, W, A, A);
      alu(LSA_OP_EXTRACT, 4'h1, W, A, 32'h7f01_fe00);
      alu(LSA_OP_LOGIC_IMM, 16'h8000, 4'h1, Z, 32'h0000_8001);
   endtask
   task automatic t_ovf;
      issue(LSA_OP_ADD_IMM, 4'h1, 32'h7fff_ffff, Z, Z);
      chk(ovf, 1'b1);
      chk(rv, 1'b0);
      alu(LSA_OP_ADD_IMM_U, 4'h1, 32'h7fff_ffff, Z, 32'h8000_0000);
      chk(ovf, 1'b0);
      alu(LSA_OP_ADD_IMM_U, 16'hffff, 8'h10, Z, 8'h0f);
   endtask
   task automatic t_md;
      alu(LSA_OP_MUL_LO_S, Z, N, 4'h3, 32'hffff_fffa);
      alu(LSA_OP_MUL_HI_S, Z, N, 4'h3, 32'hffff_ffff);
      alu(LSA_OP_MUL_LO_U, Z, N, 4'h3, 32'hffff_fffa);
      alu(LSA_OP_MUL_HI_U, Z, N, 4'h3, 4'h2);
      alu(LSA_OP_DIV_S, Z, N, 4'h3, Z);
      alu(LSA_OP_MOD_S, Z, N, 4'h3, N);
      alu(LSA_OP_DIV_U, Z, 4'h7, 4'h2, 4'h3);
      alu(LSA_OP_MOD_U, Z, 4'h7, 4'h2, 4'h1);
   endtask
   task automatic t_lanes;
      logic [7:0] by;
      logic [31:0] ex;
      int li;
      for (int k = 0; k < 8; k++) begin
         li = k[2] ? 3 - k[1:0] : k[1:0];
         by = W[8*li +: 8];
         ex = k[0] ? {{24{by[7]}}, by} : {24'h00_0000, by};
         ld(LSA_OP_LOAD, LSA_SIZE_BYTE, k[0], k[2], Z, A + k[1:0], Z,
            A + k[1:0], ex, 4'h1 << li);
      end
      ld(LSA_OP_LOAD, LSA_SIZE_HALF, 1'b1, 1'b0, Z, A + 2, Z, A + 2,
         32'hffff_8a7f, 4'hc);
      ld(LSA_OP_LOAD, LSA_SIZE_HALF, 1'b1, 1'b1, Z, A + 2, Z, A + 2,
         16'h01fe, 4'h3);
      bad(LSA_SIZE_HALF, A + 1);
      bad(LSA_SIZE_WORD, A + 2);
      st(LSA_SIZE_BYTE, 1'b0, A + 1, 32'h0000_a500);
      st(LSA_SIZE_HALF, 1'b1, A, 32'h00a5_0000);
      st(LSA_SIZE_WORD, 1'b1, A, 32'h0000_00a5);
   endtask
   task automatic t_pc;
      ld(LSA_OP_PC_WORD, LSA_SIZE_WORD, 1'b0, 1'b0, 20'h7_ffff, Z, P,
         16'h1ffc, W, 4'hf);
      ld(LSA_OP_PC_UWORD, LSA_SIZE_WORD, 1'b0, 1'b0, 4'h1, Z, P,
         16'h2008, W, 4'hf);
      ld(LSA_OP_PC_DWORD, LSA_SIZE_WORD, 1'b0, 1'b0, 20'h3_ffff, Z,
         P + 4, 16'h1ff8, W, 4'hf);
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_alu();
      t_ovf();
      t_md();
      t_lanes();
      t_pc();
      print_verdict();
   end
endmodule
